// ===== src/atten_host.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module atten_host
    import atten_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    atten_if.host_mp link
);
    host_state_e state_r;
    logic serial_r;
    logic direct_r;
    logic [CODE_W-1:0] code_r;
    logic go_r;
    logic [WORD_W-1:0] sh_r;
    logic [BIT_CNT_W-1:0] bit_r;
    logic [15:0] cnt_r;
    logic busy;
    logic wr;

    // ****************************************
    // APB registers
    // ****************************************
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign busy = (state_r != H_IDLE);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            serial_r <= 1'b0;
            direct_r <= 1'b0;
            code_r <= CODE_MIN;
        end
        else if (wr && !busy)
        begin
            if (paddr == REG_CTRL)
            begin
                serial_r <= pwdata[CTRL_SERIAL_BIT];
                direct_r <= pwdata[CTRL_DIRECT_BIT];
            end
            else if (paddr == REG_CODE)
                code_r <= pwdata[CODE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            go_r <= 1'b0;
        else
            go_r <= wr && !busy && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == REG_CTRL)
                    prdata <= {30'h0000_0000, direct_r, serial_r};
                else if (paddr == REG_CODE)
                    prdata <= {25'h000_0000, code_r};
                else if (paddr == REG_STATUS)
                    prdata <= {31'h0000_0000, busy};
                else
                    pslverr <= 1'b1;
            end
            else if (psel && !penable && pwrite)
                pslverr <= (paddr != REG_CTRL) && (paddr != REG_CODE);
        end
    end

    // ****************************************
    // Link sequencer
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r <= H_IDLE;
            sh_r <= '0;
            bit_r <= '0;
            cnt_r <= '0;
            link.serial_sel <= 1'b0;
            link.parallel_code_inputs <= '0;
            link.latch_strobe <= 1'b0;
            link.sclk <= 1'b0;
            link.sdata <= 1'b0;
        end
        else
        begin
            case (state_r)
                H_IDLE:
                begin
                    link.latch_strobe <= direct_r && !serial_r;
                    if (go_r)
                    begin
                        cnt_r <= '0;
                        link.serial_sel <= serial_r;
                        if (serial_r)
                        begin
                            link.parallel_code_inputs <= '0;
                            link.latch_strobe <= 1'b0;
                            sh_r <= {1'b0, code_r};
                            bit_r <= '0;
                            state_r <= H_SHIFT_LO;
                        end
                        else
                        begin
                            link.parallel_code_inputs <= code_r;
                            state_r <= direct_r ? H_GAP : H_PAR_SETUP;
                        end
                    end
                end
                H_SHIFT_LO:
                begin
                    link.sclk <= 1'b0;
                    link.sdata <= sh_r[0];
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(SCLK_HALF_CYC - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= H_SHIFT_HI;
                    end
                end
                H_SHIFT_HI:
                begin
                    link.sclk <= 1'b1;
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(SCLK_HALF_CYC - 1))
                    begin
                        cnt_r <= '0;
                        sh_r <= {1'b0, sh_r[WORD_W-1:1]};
                        bit_r <= bit_r + 4'h1;
                        state_r <= (bit_r == 4'(WORD_W - 1)) ? H_PAR_SETUP : H_SHIFT_LO;
                    end
                end
                H_PAR_SETUP:
                begin
                    link.sclk <= 1'b0;
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(STROBE_CYC - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= H_STROBE;
                    end
                end
                H_STROBE:
                begin
                    link.latch_strobe <= 1'b1;
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(STROBE_CYC - 1))
                    begin
                        cnt_r <= '0;
                        link.latch_strobe <= 1'b0;
                        state_r <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(UPDATE_GAP_CYC - 1))
                        state_r <= H_IDLE;
                end
                default:
                    state_r <= H_IDLE;
            endcase
        end
    end
endmodule

// ===== src/atten_pkg.sv
package atten_pkg;

    // ****************************************
    // Word layout
    // ****************************************
    localparam int CODE_W = 7;
    localparam int WORD_W = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [CODE_W-1:0] CODE_MAX = 7'h7f;
    localparam logic [CODE_W-1:0] CODE_MIN = 7'h00;
    localparam logic [WORD_W-1:0] WORD_MAX = 8'h7f;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int POWERUP_HOLD_US = 400;
    localparam int POWERUP_HOLD_CYC = (POWERUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UPDATE_RATE_HZ = 25000;
    localparam int UPDATE_GAP_CYC = (1000000000 / UPDATE_RATE_HZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 4;
    localparam int STROBE_CYC = 4;

    // ****************************************
    // Host command states
    // ****************************************
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SHIFT_LO = 3'b001,
        H_SHIFT_HI = 3'b010,
        H_STROBE = 3'b011,
        H_PAR_SETUP = 3'b100,
        H_GAP = 3'b101
    } host_state_e;

    // ****************************************
    // Host register map, byte addresses
    // ****************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CODE = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_DIRECT_BIT = 1;
    localparam int CTRL_GO_BIT = 2;

endpackage

// ===== src/atten_if.sv
`timescale 1ns/1ps
interface atten_if;
    logic serial_sel;
    logic [6:0] parallel_code_inputs;
    logic latch_strobe;
    logic sclk;
    logic sdata;

    modport host_mp (
        output serial_sel, parallel_code_inputs, latch_strobe, sclk, sdata
    );
    modport dev_mp (
        input serial_sel, parallel_code_inputs, latch_strobe, sclk, sdata
    );
endinterface

// ===== src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_r <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ===== src/step_attenuator_ctrl.sv
`timescale 1ns/1ps
module step_attenuator_ctrl
    import atten_pkg::*;
#(
    parameter int HOLD_CYC = POWERUP_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Link
    atten_if.dev_mp link,
    // Attenuator core
    output logic [WORD_W-1:0] atten_word_o,
    output logic [CODE_W-1:0] atten_code_o,
    output logic powerup_busy_o
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [CODE_W+3:0] pins_s;
    logic sel_s;
    logic le_s;
    logic sclk_s;
    logic sdi_s;
    logic [CODE_W-1:0] pcode_s;

    sync2 #(.W(CODE_W + 4)) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .d_i({link.serial_sel, link.latch_strobe, link.sclk, link.sdata,
              link.parallel_code_inputs}),
        .q_o(pins_s)
    );
    assign {sel_s, le_s, sclk_s, sdi_s, pcode_s} = pins_s;

    // ****************************************
    // Edge detection
    // ****************************************
    logic sclk_d_r;
    logic le_d_r;
    logic sclk_rise;
    logic le_rise;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sclk_d_r <= 1'b0;
            le_d_r <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            le_d_r <= le_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign le_rise = le_s & ~le_d_r;

    // ****************************************
    // Serial shift register, LSB first
    // ****************************************
    logic [WORD_W-1:0] shift_r;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            shift_r <= '0;
        else if (sel_s && !le_s && sclk_rise)
            shift_r <= {sdi_s, shift_r[WORD_W-1:1]};
    end

    // ****************************************
    // Serial latch
    // ****************************************
    logic [WORD_W-1:0] ser_word_r;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ser_word_r <= WORD_MAX;
        else if (sel_s && le_rise)
            ser_word_r <= shift_r;
    end

    // ****************************************
    // Parallel latch and power-up hold
    // ****************************************
    logic [CODE_W-1:0] par_code_r;
    logic [$clog2(HOLD_CYC+1)-1:0] hold_cnt_r;
    logic hold_r;
    logic settled_r;
    logic direct_at_pwrup_r;
    logic hold_max;

    // Both synchroniser stages carry pin values from this count on
    localparam int SETTLE_CNT = 2;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            settled_r <= 1'b0;
        else if (hold_cnt_r == ($clog2(HOLD_CYC+1))'(SETTLE_CNT))
            settled_r <= 1'b1;
    end

    // Mode seen once pins are trusted decides whether the hold applies
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            direct_at_pwrup_r <= 1'b0;
        else if (!settled_r && hold_cnt_r == ($clog2(HOLD_CYC+1))'(SETTLE_CNT))
            direct_at_pwrup_r <= ~sel_s & le_s;
    end

    // Maximum forced until the mode is known, then only for direct mode
    assign hold_max = hold_r & (~settled_r | direct_at_pwrup_r);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hold_cnt_r <= '0;
            hold_r <= 1'b1;
        end
        else if (hold_r)
        begin
            if (hold_cnt_r == ($clog2(HOLD_CYC+1))'(HOLD_CYC - 1))
                hold_r <= 1'b0;
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            par_code_r <= CODE_MAX;
        else if (!sel_s && le_rise)
            par_code_r <= pcode_s;
    end

    // ****************************************
    // Core source
    // ****************************************
    logic [CODE_W-1:0] code_nxt;

    always_comb
    begin
        if (sel_s)
            code_nxt = ser_word_r[CODE_W-1:0];
        else if (le_s)
        begin
            // Pulldown-free pins read low when floating
            if (hold_max)
                code_nxt = CODE_MAX;
            else
                code_nxt = pcode_s;
        end
        else
            code_nxt = par_code_r;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            atten_code_o <= CODE_MAX;
            atten_word_o <= WORD_MAX;
        end
        else
        begin
            atten_code_o <= code_nxt;
            atten_word_o <= sel_s ? ser_word_r : {1'b0, code_nxt};
        end
    end

    // ****************************************
    // Power-up status
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            powerup_busy_o <= 1'b1;
        else
            powerup_busy_o <= hold_max;
    end
endmodule

// ===== testbench/atten_sva.sv
`timescale 1ns/1ps
module atten_sva
    import atten_pkg::*;
#(
    parameter int HOLD_CYC = POWERUP_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Link
    input wire logic serial_sel,
    input wire logic [6:0] parallel_code_inputs,
    input wire logic latch_strobe,
    input wire logic sclk,
    input wire logic sdata,
    // Core
    input wire logic [WORD_W-1:0] atten_word_o,
    input wire logic [CODE_W-1:0] atten_code_o,
    input wire logic powerup_busy_o
);
    // ****************************************
    // Shadow of the serial word
    // ****************************************
    logic [WORD_W-1:0] shadow_r;
    int busy_cnt_r;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            shadow_r <= WORD_MAX;
        else if (serial_sel && !latch_strobe && $rose(sclk))
            shadow_r <= {sdata, shadow_r[WORD_W-1:1]};
    end
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            busy_cnt_r <= 0;
        else if (powerup_busy_o)
            busy_cnt_r <= busy_cnt_r + 1;
        else
            busy_cnt_r <= 0;
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    chk_shift_clean: assert property (
        $rose(sclk) |-> serial_sel && !latch_strobe && parallel_code_inputs == '0)
        else $error("shift with strobe high or pins set");
    chk_hold_shift: assert property ($rose(sclk) |-> ##3 $stable(atten_code_o)[*4])
        else $error("applied code moved while shifting");
    chk_serial_word: assert property (
        $rose(latch_strobe) && serial_sel |-> ##[2:8] atten_word_o == shadow_r)
        else $error("latched word differs from shifted bits");
    chk_strobe_width: assert property (
        $rose(latch_strobe) && serial_sel |=> latch_strobe[*2] ##1 !latch_strobe)
        else $error("serial strobe pulse width wrong");
    chk_latch_par: assert property (
        !serial_sel && $rose(latch_strobe) |-> ##[2:8] atten_code_o == parallel_code_inputs)
        else $error("latched parallel code not applied");
    chk_direct_follow: assert property (
        !serial_sel && latch_strobe && !powerup_busy_o && $changed(parallel_code_inputs)
        |-> ##[2:8] atten_code_o == parallel_code_inputs)
        else $error("direct code not followed");
    chk_sel_source: assert property (
        $rose(serial_sel) |-> ##[2:8] atten_word_o == shadow_r)
        else $error("serial word not applied after select");
    chk_code_word: assert property (atten_word_o[6:0] == atten_code_o)
        else $error("code and word disagree");
    chk_busy_max: assert property (powerup_busy_o |-> atten_code_o == CODE_MAX)
        else $error("hold without maximum code");
    chk_hold_len: assert property (busy_cnt_r <= HOLD_CYC + 2)
        else $error("power-up hold too long");
    cover property ($rose(latch_strobe) && serial_sel);
    cover property ($fell(powerup_busy_o));
    cover property (!serial_sel && latch_strobe && $changed(parallel_code_inputs));
endmodule

// ===== testbench/step_attenuator_control_port_tb.sv
`timescale 1ns/1ps
module step_attenuator_control_port_tb
    import atten_pkg::*;
;
    localparam int HOLD = 20;
    logic clk_sys_i, arst_n_i, dev_rst_n, arst_dev_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [WORD_W-1:0] word;
    logic [CODE_W-1:0] code;
    logic busy, err;
    int fail_count, checks;
    assign arst_dev_n = arst_n_i & dev_rst_n;
    atten_if link_if();
    atten_host i_atten_host (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link_if));
    step_attenuator_ctrl #(.HOLD_CYC(HOLD)) i_step_attenuator_ctrl (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_dev_n), .link(link_if), .atten_word_o(word), .atten_code_o(code),
        .powerup_busy_o(busy));
    atten_sva #(.HOLD_CYC(HOLD)) i_atten_sva (.clk_sys_i(clk_sys_i), .arst_n_i(arst_dev_n),
        .serial_sel(link_if.serial_sel), .parallel_code_inputs(link_if.parallel_code_inputs),
        .latch_strobe(link_if.latch_strobe), .sclk(link_if.sclk), .sdata(link_if.sdata),
        .atten_word_o(word), .atten_code_o(code), .powerup_busy_o(busy));
    // ****************************************
    // Shared tasks
    // ****************************************
    task results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task timeout(input string what);
        fail_count++;
        $display("MISMATCH %0t timeout %s", $time, what);
        results();
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            timeout("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task send(input logic [2:0] mode, input logic [6:0] c);
        int n;
        apb(1'b1, REG_CODE, {25'h0, c});
        apb(1'b1, REG_CTRL, {29'h0, mode});
        n = 0;
        do
        begin
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 1000);
        if (rd[0] !== 1'b0)
            timeout("idle");
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_power_on;
        check(code, 32'h0000_007f, "reset code");
        check(word, 32'h0000_007f, "reset word");
        check(busy, 32'h0000_0000, "no hold when latched");
    endtask
    task t_serial;
        logic [6:0] tbl [10];
        tbl = '{7'h32, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h7f, 7'h00};
        foreach (tbl[i])
        begin
            send(3'h5, tbl[i]);
            check(code, {25'h0, tbl[i]}, "serial code");
            check(word, {24'h0, 1'b0, tbl[i]}, "serial word");
        end
        apb(1'b0, REG_CODE, 32'h0000_0000);
        check(rd[6:0], 32'h0000_0000, "code readback");
    endtask
    task t_latched;
        logic [6:0] tbl [3];
        tbl = '{7'h55, 7'h2a, 7'h7f};
        foreach (tbl[i])
        begin
            send(3'h4, tbl[i]);
            check(code, {25'h0, tbl[i]}, "latched code");
        end
    endtask
    task t_direct;
        send(3'h6, 7'h0c);
        check(link_if.latch_strobe, 32'h0000_0001, "strobe held");
        check(code, 32'h0000_000c, "direct code");
        send(3'h6, 7'h73);
        check(code, 32'h0000_0073, "direct code");
    endtask
    task t_powerup;
        int n;
        send(3'h6, 7'h15);
        @(posedge clk_sys_i);
        dev_rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        dev_rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check(busy, 32'h0000_0001, "hold active");
        check(code, 32'h0000_007f, "hold code");
        n = 2;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        check(n >= HOLD - 2 && n <= HOLD + 4, 32'h0000_0001, "hold length");
        repeat (4) @(posedge clk_sys_i);
        check(code, 32'h0000_0015, "preset code");
    endtask
    task t_unmapped;
        apb(1'b0, 12'h00c, 32'h0000_0000);
        check(err, 32'h0000_0001, "unmapped error");
        apb(1'b0, REG_CODE, 32'h0000_0000);
        check(err, 32'h0000_0000, "mapped no error");
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        arst_n_i = 1'b0;
        dev_rst_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        checks = 0;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        t_power_on();
        t_serial();
        t_latched();
        t_direct();
        t_powerup();
        t_unmapped();
        t_serial();
        results();
    end
endmodule
